// ==== csf_cfg.svh ====
/*
 Offsets, field positions, reset values and masks of the charger status and event flag bank.
 Assumes inclusion by bare name from the package and modules.
*/
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH
`define CSF_OFF_STATUS_ONE   8'h0b
`define CSF_OFF_STATUS_TWO   8'h0c
`define CSF_OFF_THERMISTOR   8'h0d
`define CSF_OFF_FAULT        8'h0e
`define CSF_OFF_FLAGS_ONE    8'h0f
`define CSF_OFF_FLAGS_TWO    8'h10
`define CSF_FLAGS_RESET      8'h00
`define CSF_FLAGS_ONE_USED   8'hf9
`define CSF_FLAGS_TWO_USED   8'h97
`define CSF_BIT_CONV_DONE    7
`define CSF_BIT_ICUR         6
`define CSF_BIT_IVOLT        5
`define CSF_BIT_THERM        4
`define CSF_BIT_WDOG         3
`define CSF_BIT_PHASE        0
`define CSF_BIT_PGOOD        7
`define CSF_BIT_SOURCE       4
`define CSF_BIT_TZONE        2
`define CSF_BIT_OPT          1
`define CSF_BIT_MINSYS       0
`define CSF_PHASE_RESERVED   3'h7
`define CSF_OPT_RESERVED     2'h3
`endif

// ==== csf_pkg.sv ====
/*
 Types of the charger status and event flag bank.
 Assumes csf_cfg.svh is on the include path.
*/
`include "csf_cfg.svh"
package csf_pkg;
   // Live conditions from the analog and control sections
   typedef struct packed {
      logic       conv_done;
      logic       input_current_loop_active;
      logic       input_voltage_loop_active;
      logic       thermal_loop_active;
      logic       watchdog_expired_status;
      logic [2:0] charge_phase;
      logic       input_power_good;
      logic [2:0] source_type;
      logic [1:0] optimizer_state;
      logic       min_system_loop_active;
      logic [2:0] thermistor_zone;
      logic       input_overvoltage_status;
      logic       thermal_shutdown_status;
      logic       battery_overvoltage_status;
      logic       safety_timer_expired_status;
   } csf_cond_s;
   typedef enum logic [1:0] {CSF_EDGE_RISE, CSF_EDGE_ANY} csf_edge_e;
endpackage

// ==== csf_edge_det.sv ====
/*
 Change detector for one condition field: flags a rise of the lsb or any change.
 Assumes prev_i is the field delayed one clock, by the same clock; neither is reset, so valid_i masks the first compare.
*/
`timescale 1ns/10ps
`include "csf_cfg.svh"
module csf_edge_det
   import csf_pkg::*;
#(
   parameter int        W    = 1,
   parameter csf_edge_e KIND = CSF_EDGE_ANY
) (
   // Field now and one clock ago
   input  wire logic [W-1:0] cur_i,
   input  wire logic [W-1:0] prev_i,
   input  wire logic         valid_i,
   // Event
   output logic              evt_o
);
   wire logic rise_w = cur_i[0] & ~prev_i[0];
   wire logic diff_w = (cur_i != prev_i);
   assign evt_o = valid_i & ((KIND == CSF_EDGE_RISE) ? rise_w : diff_w);
endmodule // csf_edge_det

// ==== csf_status_flags.sv ====
/*
 Charger status and read-to-clear event flag registers.
 Assumes conditions are asynchronous to clk_i and are synchronised here; the
 serial port logic presents one-cycle read strobes with an address and takes
 data on the cycle after the strobe.
*/
`timescale 1ns/10ps
`include "csf_cfg.svh"
module csf_status_flags
   import csf_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   // Register reset command, one-cycle pulse
   input  wire logic       reg_reset_i,
   // Live conditions
   input  wire csf_cond_s  cond_i,
   input  wire logic       conv_continuous_i,
   // Event masks
   input  wire logic [7:0] mask_one_i,
   input  wire logic [7:0] mask_two_i,
   // Register read port
   input  wire logic       rd_i,
   input  wire logic [7:0] rd_addr_i,
   output logic [7:0]      rd_data_o,
   output logic            rd_valid_o,
   // Interrupt pulse to the host side
   output logic            int_pulse_o
);
   // Two-stage synchroniser on all condition inputs
   csf_cond_s cond_s1_r;
   csf_cond_s cond_r;
   csf_cond_s prev_r;
   logic      cont_s1_r;
   logic      cont_r;
   logic      prev_ok_r;
   logic [7:0] flags_one_r;
   logic [7:0] flags_two_r;
   logic [7:0] rd_data_r;
   logic       rd_valid_r;
   logic       int_r;

   always_ff @(posedge clk_i) begin
      cond_s1_r <= cond_i;
      cond_r    <= cond_s1_r;
      cont_s1_r <= conv_continuous_i;
      cont_r    <= cont_s1_r;
      prev_r    <= cond_r;
   end

   // Suppresses false events on the first compare after reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         prev_ok_r <= 1'b0;
      end else begin
         prev_ok_r <= 1'b1;
      end
   end

   // Live status images, not reset
   wire logic       done_w = cond_r.conv_done & ~cont_r;
   wire logic [7:0] stat_one_w = {done_w,
                                  cond_r.input_current_loop_active,
                                  cond_r.input_voltage_loop_active,
                                  cond_r.thermal_loop_active,
                                  cond_r.watchdog_expired_status,
                                  cond_r.charge_phase};
   wire logic [7:0] stat_two_w = {cond_r.input_power_good,
                                  cond_r.source_type,
                                  1'b0,
                                  cond_r.optimizer_state,
                                  cond_r.min_system_loop_active};
   wire logic [7:0] stat_tz_w = {5'h00, cond_r.thermistor_zone};
   wire logic [7:0] stat_flt_w = {cond_r.input_overvoltage_status,
                                  cond_r.thermal_shutdown_status,
                                  cond_r.battery_overvoltage_status,
                                  cond_r.safety_timer_expired_status,
                                  4'h0};

   // Event detection
   logic [7:0] ev_one_w;
   logic [7:0] ev_two_w;
   logic       prev_done_w;
   assign prev_done_w = prev_r.conv_done & ~cont_r;

   csf_edge_det #(.W(1), .KIND(CSF_EDGE_RISE)) u_done (
      .cur_i   (done_w),
      .prev_i  (prev_done_w),
      .valid_i (prev_ok_r),
      .evt_o   (ev_one_w[`CSF_BIT_CONV_DONE])
   );

   // Input current, input voltage and thermal loops and watchdog each get their own rising-edge detector
   localparam int LOOPS = 4;
   wire logic [LOOPS-1:0] loop_cur_w = stat_one_w[6:3];
   wire logic [LOOPS-1:0] loop_prev_w = {prev_r.input_current_loop_active,
                                         prev_r.input_voltage_loop_active,
                                         prev_r.thermal_loop_active,
                                         prev_r.watchdog_expired_status};
   genvar g;
   generate
      for (g = 0; g < LOOPS; g++) begin : g_loop
         csf_edge_det #(.W(1), .KIND(CSF_EDGE_RISE)) u_rise (
            .cur_i   (loop_cur_w[g]),
            .prev_i  (loop_prev_w[g]),
            .valid_i (prev_ok_r),
            .evt_o   (ev_one_w[3+g])
         );
      end
   endgenerate

   csf_edge_det #(.W(3), .KIND(CSF_EDGE_ANY)) u_phase (
      .cur_i   (cond_r.charge_phase),
      .prev_i  (prev_r.charge_phase),
      .valid_i (prev_ok_r),
      .evt_o   (ev_one_w[`CSF_BIT_PHASE])
   );
   assign ev_one_w[2:1] = 2'h0;

   csf_edge_det #(.W(1), .KIND(CSF_EDGE_ANY)) u_pg (
      .cur_i   (cond_r.input_power_good),
      .prev_i  (prev_r.input_power_good),
      .valid_i (prev_ok_r),
      .evt_o   (ev_two_w[`CSF_BIT_PGOOD])
   );
   csf_edge_det #(.W(3), .KIND(CSF_EDGE_ANY)) u_src (
      .cur_i   (cond_r.source_type),
      .prev_i  (prev_r.source_type),
      .valid_i (prev_ok_r),
      .evt_o   (ev_two_w[`CSF_BIT_SOURCE])
   );
   csf_edge_det #(.W(3), .KIND(CSF_EDGE_ANY)) u_tz (
      .cur_i   (cond_r.thermistor_zone),
      .prev_i  (prev_r.thermistor_zone),
      .valid_i (prev_ok_r),
      .evt_o   (ev_two_w[`CSF_BIT_TZONE])
   );
   csf_edge_det #(.W(2), .KIND(CSF_EDGE_ANY)) u_opt (
      .cur_i   (cond_r.optimizer_state),
      .prev_i  (prev_r.optimizer_state),
      .valid_i (prev_ok_r),
      .evt_o   (ev_two_w[`CSF_BIT_OPT])
   );
   csf_edge_det #(.W(1), .KIND(CSF_EDGE_ANY)) u_min (
      .cur_i   (cond_r.min_system_loop_active),
      .prev_i  (prev_r.min_system_loop_active),
      .valid_i (prev_ok_r),
      .evt_o   (ev_two_w[`CSF_BIT_MINSYS])
   );
   assign ev_two_w[6:5] = 2'h0;
   assign ev_two_w[3]   = 1'b0;

   // Read decode
   wire logic rd_f1_w = rd_i & (rd_addr_i == `CSF_OFF_FLAGS_ONE);
   wire logic rd_f2_w = rd_i & (rd_addr_i == `CSF_OFF_FLAGS_TWO);

   function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input logic [7:0] s1, input logic [7:0] s2,
                                          input logic [7:0] tz, input logic [7:0] fl,
                                          input logic [7:0] f1, input logic [7:0] f2);
      case (a)
         `CSF_OFF_STATUS_ONE: read_mux = s1;
         `CSF_OFF_STATUS_TWO: read_mux = s2;
         `CSF_OFF_THERMISTOR: read_mux = tz;
         `CSF_OFF_FAULT:      read_mux = fl;
         `CSF_OFF_FLAGS_ONE:  read_mux = f1;
         `CSF_OFF_FLAGS_TWO:  read_mux = f2;
         default:             read_mux = 8'h00;
      endcase
   endfunction

   // Continuous conversion hides the done flag
   wire logic [7:0] f1_view_w = flags_one_r & ~{cont_r, 7'h00};
   wire logic [7:0] rd_mux_w = read_mux(rd_addr_i, stat_one_w, stat_two_w, stat_tz_w,
                                        stat_flt_w, f1_view_w, flags_two_r);

   // Clear exactly what is returned; a same-cycle event wins the set
   wire logic [7:0] clr_one_w = rd_f1_w ? f1_view_w : 8'h00;
   wire logic [7:0] clr_two_w = rd_f2_w ? flags_two_r : 8'h00;
   wire logic [7:0] f1_nxt = ((flags_one_r & ~clr_one_w) | ev_one_w)
                             & `CSF_FLAGS_ONE_USED & ~{cont_r, 7'h00};
   wire logic [7:0] f2_nxt = ((flags_two_r & ~clr_two_w) | ev_two_w) & `CSF_FLAGS_TWO_USED;
   wire logic       int_nxt = |(ev_one_w & ~mask_one_i) | |(ev_two_w & ~mask_two_i);

   always_ff @(posedge clk_i) begin
      if (!resetn_i || reg_reset_i) begin
         flags_one_r <= `CSF_FLAGS_RESET;
         flags_two_r <= `CSF_FLAGS_RESET;
      end else begin
         flags_one_r <= f1_nxt;
         flags_two_r <= f2_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
         int_r      <= 1'b0;
      end else begin
         rd_data_r  <= rd_i ? rd_mux_w : rd_data_r;
         rd_valid_r <= rd_i;
         int_r      <= int_nxt;
      end
   end

   assign rd_data_o   = rd_data_r;
   assign rd_valid_o  = rd_valid_r;
   assign int_pulse_o = int_r;
endmodule // csf_status_flags

// ==== csf_status_flags_chk.sv ====
/* Port assertions for the status and event flag bank.
   Assumes it is bound to csf_status_flags; one clock domain. */
`timescale 1ns/10ps
module csf_status_flags_chk
   import csf_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       reg_reset_i,
   input wire csf_cond_s  cond_i,
   input wire logic       conv_continuous_i,
   input wire logic [7:0] mask_one_i,
   input wire logic [7:0] mask_two_i,
   input wire logic       rd_i,
   input wire logic [7:0] rd_addr_i,
   input wire logic [7:0] rd_data_o,
   input wire logic       rd_valid_o,
   input wire logic       int_pulse_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [7:0] addr_r;
   always_ff @(posedge clk_i) addr_r <= rd_addr_i;
   chk_zone_upper_zero: assert property (rd_valid_o && addr_r == 8'h0d |-> rd_data_o[7:3] == 5'h00)
      else $error("thermistor upper bits set");
   chk_fault_low_zero: assert property (rd_valid_o && addr_r == 8'h0e |-> rd_data_o[3:0] == 4'h0)
      else $error("fault low bits set");
   chk_flag_one_resv: assert property (rd_valid_o && addr_r == 8'h0f |-> rd_data_o[2:1] == 2'h0)
      else $error("flag one reserved bits set");
   chk_flag_two_resv: assert property (rd_valid_o && addr_r == 8'h10 |-> !rd_data_o[6] && !rd_data_o[5] && !rd_data_o[3])
      else $error("flag two reserved bits set");
   chk_cont_done_zero: assert property (rd_valid_o && (addr_r == 8'h0b || addr_r == 8'h0f)
      && $past(conv_continuous_i, 2) && $past(conv_continuous_i, 3) && $past(conv_continuous_i, 4)
      |-> !rd_data_o[7])
      else $error("done bit set in continuous mode");
   chk_reset_quiet: assert property (disable iff (1'b0) !resetn_i |=> !rd_valid_o && !int_pulse_o && rd_data_o == 8'h00)
      else $error("outputs active during reset");
   chk_read_answer: assert property (rd_valid_o == $past(rd_i))
      else $error("read answer not one cycle after strobe");
   chk_mask_silent: assert property ($past(mask_one_i) == 8'hff && $past(mask_two_i) == 8'hff |-> !int_pulse_o)
      else $error("masked event pulsed interrupt");
endmodule // csf_status_flags_chk

// ==== csf_host_model.sv ====
/* Host side of the register read port.
   Assumes the bench calls read(); one strobe per call, data taken a cycle later. */
`timescale 1ns/10ps
module csf_host_model (
   // Clock
   input  wire logic       clk_i,
   // Read port
   output logic            rd_o,
   output logic [7:0]      addr_o,
   input  wire logic [7:0] data_i,
   input  wire logic       valid_i
);
   initial begin
      rd_o = 1'b0;
      addr_o = 8'h00;
   end
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_i);
      #1;
      rd_o = 1'b1;
      addr_o = a;
      @(posedge clk_i);
      #1;
      rd_o = 1'b0;
      // Stale address must not matter once the strobe is gone
      addr_o = ~a;
      d = data_i;
      v = valid_i;
   endtask
endmodule // csf_host_model

// ==== csf_status_flags_tb.sv ====
/* Self-checking bench of the status and flag bank.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/10ps
module csf_status_flags_tb
   import csf_pkg::*;
;
   logic       clk_i = 0, resetn_i = 0, reg_reset_i = 0, conv_continuous_i = 0, rd_i, rd_valid_o, int_pulse_o, v;
   logic [7:0] mask_one_i = 8'h00, mask_two_i = 8'h00, rd_addr_i, rd_data_o, d;
   csf_cond_s  cond_i = '0;
   int         error_cnt = 0, n_tests = 0, cyc = 0, n_int = 0, k;
   logic [2:0] zt [8] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h0, 3'h2, 3'h3};
   csf_host_model h (.clk_i(clk_i), .rd_o(rd_i), .addr_o(rd_addr_i), .data_i(rd_data_o), .valid_i(rd_valid_o));
   csf_status_flags dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_reset_i(reg_reset_i), .cond_i(cond_i),
      .conv_continuous_i(conv_continuous_i), .mask_one_i(mask_one_i), .mask_two_i(mask_two_i), .rd_i(rd_i),
      .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .int_pulse_o(int_pulse_o));
   initial forever #2 clk_i = ~clk_i;
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (int_pulse_o === 1'b1) n_int++;
      // Whole sequence needs well under a thousand cycles
      if (cyc == 3000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      h.read(a, d, v);
      chk(exp, (v === 1'b1) ? d : ~exp);
   endtask
   // Covers the three-edge flag latency with margin
   task automatic settle();
      repeat (6) @(posedge clk_i);
      #1;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      #1 resetn_i = 1;
      rdchk(8'h0f, 8'h00);
      rdchk(8'h10, 8'h00);
      rdchk(8'h11, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         cond_i = {i[0], i[1], i[2], i[0], i[1], 3'(i % 7), i[2], i[2:0], 2'(i % 3), i[0], zt[i], i[0], i[1], i[2], i[1]};
         settle();
         rdchk(8'h0b, {i[0], i[1], i[2], i[0], i[1], 3'(i % 7)});
         rdchk(8'h0c, {i[2], i[2:0], 1'b0, 2'(i % 3), i[0]});
         rdchk(8'h0d, {5'h00, zt[i]});
         rdchk(8'h0e, {i[0], i[1], i[2], i[1], 4'h0});
      end
      $display("test status mirror done");
      cond_i = '0;
      settle();
      h.read(8'h0f, d, v);
      h.read(8'h10, d, v);
      k = n_int;
      cond_i = {5'h1f, 3'h1, 1'b1, 3'h1, 2'h1, 1'b1, 3'h2, 4'h0};
      settle();
      chk(8'h01, {7'h0, n_int > k});
      rdchk(8'h0f, 8'hf9);
      rdchk(8'h10, 8'h97);
      rdchk(8'h0f, 8'h00);
      rdchk(8'h10, 8'h00);
      cond_i = '0;
      settle();
      rdchk(8'h0f, 8'h01);
      rdchk(8'h10, 8'h97);
      $display("test event flags done");
      cond_i.input_current_loop_active = 1'b1;
      settle();
      reg_reset_i = 1'b1;
      @(posedge clk_i);
      #1 reg_reset_i = 1'b0;
      rdchk(8'h0f, 8'h00);
      rdchk(8'h10, 8'h00);
      mask_one_i = 8'hff;
      mask_two_i = 8'hff;
      k = n_int;
      cond_i.input_power_good = 1'b1;
      settle();
      chk(8'h00, {7'h0, n_int > k});
      mask_one_i = 8'h00;
      mask_two_i = 8'h00;
      conv_continuous_i = 1'b1;
      settle();
      cond_i.conv_done = 1'b1;
      settle();
      rdchk(8'h0b, 8'h40);
      rdchk(8'h0f, 8'h00);
      $display("test reset command, mask and mode done");
      final_report();
   end
endmodule // csf_status_flags_tb
bind csf_status_flags csf_status_flags_chk chk (.clk_i(clk_i), .resetn_i(resetn_i), .reg_reset_i(reg_reset_i),
   .cond_i(cond_i), .conv_continuous_i(conv_continuous_i), .mask_one_i(mask_one_i), .mask_two_i(mask_two_i),
   .rd_i(rd_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .int_pulse_o(int_pulse_o));
